// *** wld_pkg.sv ***
package wld_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] ADDR_TRIP_LEVEL  = 4'h0;
  localparam logic [3:0] ADDR_CTRL_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'hC;

  // Field positions in light_control_status_reg
  localparam int DEB_MSB   = 7;
  localparam int DEB_LSB   = 4;
  localparam int JAM_BIT   = 3;
  localparam int EVT_BIT   = 0;

  // Reset values
  localparam logic [7:0] TRIP_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Interrupt status bit positions
  localparam int IRQ_EVT  = 0;
  localparam int IRQ_JAM  = 1;
  localparam int IRQ_W    = 2;

  // Anti-jam guard figures: an event count, then window and quiet interval in light sample periods
  localparam logic [3:0]  JAM_EVENTS   = 4'hC;
  localparam logic [15:0] JAM_WINDOW   = 16'h0100;
  localparam logic [15:0] QUIET_PERIOD = 16'h0400;

  // Light sample carrier
  typedef struct packed {
    logic       valid;
    logic [7:0] level;
  } wld_sample_t;

  // Guard states
  typedef enum logic [1:0] {
    WLD_WATCH,
    WLD_JAMMED
  } wld_guard_t;
endpackage

// *** wld_detector.sv ***
`timescale 1ns/1ps
// Functional notes
// - Eight-bit trip level; larger value means less sensitive detection.
// - Trip level zero disables detection; no light event ever.
// - Event needs consecutive over-level samples reaching the 4-bit debounce count.
// - Control bit 3 enables the anti-jam guard when one.
// - Guard on: twelve events within window, then ignore events, motion resumes.
// - Ignoring events ends after a quiet interval with no events.
// - Guard off: every event inhibits motion, possibly indefinitely.
// - Status bit 0 sets when a light event is reported, not for the event that jams or events while jammed.
// - Event flag stays set until software clears it.
module wld_detector (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire wld_pkg::wld_sample_t  sample_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       motion_inhibit_o,
  output logic                       light_event_o,
  output logic                       irq_o
);
  // Software registers
  logic [7:0]          light_trip_level_reg;
  logic [7:0]          ctrl_r;
  logic [wld_pkg::IRQ_W-1:0] irq_stat_r;
  logic [wld_pkg::IRQ_W-1:0] irq_mask_r;
  // Debounce and guard state
  logic [3:0]          run_r;
  logic [3:0]          evt_cnt_r;
  logic [15:0]         win_r;
  logic [15:0]         quiet_r;
  wld_pkg::wld_guard_t guard_r;
  // Decoded strobes and helper values
  logic                declare;
  logic                over;
  logic                wr_hit;
  logic                req_live;
  logic                jam_start;
  logic                at_limit;
  logic [3:0]          deb_need;
  logic [3:0]          run_next;
  logic                watching;
  logic                win_done;
  logic                quiet_done;
  logic                report;
  logic [wld_pkg::IRQ_W-1:0] irq_set;
  logic [wld_pkg::IRQ_W-1:0] irq_clr;
  logic [31:0]         rd_word;
  logic [7:0]          light_control_status_reg;

  // Byte-lane write decode for one register
  function automatic logic wr_to(input logic [3:0] a, input logic [3:0] off);
    wr_to = wr_hit && (a == off);
  endfunction

  // A request is live until its ack; writes land on the take edge only
  assign req_live = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_hit   = req_live && wb_we_i && wb_sel_i[0];
  assign light_control_status_reg = ctrl_r;

  // Sample compare; a zero trip level turns detection off
  assign over = (light_trip_level_reg != 8'h00) && sample_i.valid
              && (sample_i.level > light_trip_level_reg);

  // Debounce target; a count of zero behaves as one
  assign deb_need = ctrl_r[wld_pkg::DEB_MSB:wld_pkg::DEB_LSB];
  assign run_next = run_r + 4'h1;
  assign declare  = over && (run_next >= deb_need);

  // Consecutive over-level run counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 4'h0;
    end else if (sample_i.valid) begin
      if (!over || declare) begin
        run_r <= 4'h0;
      end else begin
        run_r <= run_r + 4'h1;
      end
    end
  end

  // Twelfth event inside the window engages the guard and is not reported
  assign at_limit  = (evt_cnt_r == wld_pkg::JAM_EVENTS - 4'h1);
  assign jam_start = ctrl_r[wld_pkg::JAM_BIT] && (guard_r == wld_pkg::WLD_WATCH) && declare
                   && at_limit;

  // Guard timing strobes
  assign watching   = (guard_r == wld_pkg::WLD_WATCH);
  assign win_done   = watching && sample_i.valid && !declare && (evt_cnt_r != 4'h0)
                    && (win_r >= wld_pkg::JAM_WINDOW - 16'h0001);
  assign quiet_done = !watching && sample_i.valid && !declare
                    && (quiet_r >= wld_pkg::QUIET_PERIOD - 16'h0001);

  // Guard state: watching for events, or ignoring them while jammed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      guard_r <= wld_pkg::WLD_WATCH;
    end else if (!ctrl_r[wld_pkg::JAM_BIT]) begin
      guard_r <= wld_pkg::WLD_WATCH;
    end else begin
      case (guard_r)
        wld_pkg::WLD_WATCH: begin
          if (jam_start) begin
            guard_r <= wld_pkg::WLD_JAMMED;
          end
        end
        wld_pkg::WLD_JAMMED: begin
          if (quiet_done) begin
            guard_r <= wld_pkg::WLD_WATCH;
          end
        end
        default: begin
          guard_r <= wld_pkg::WLD_WATCH;
        end
      endcase
    end
  end

  // Events seen in the current window while watching
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_cnt_r <= 4'h0;
    end else if (!ctrl_r[wld_pkg::JAM_BIT] || jam_start) begin
      evt_cnt_r <= 4'h0;
    end else if (watching && sample_i.valid) begin
      if (declare) begin
        evt_cnt_r <= evt_cnt_r + 4'h1;
      end else if (win_done) begin
        evt_cnt_r <= 4'h0;
      end
    end
  end

  // Window age: restarts at the first event, counts quiet samples after it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_r <= 16'h0000;
    end else if (!ctrl_r[wld_pkg::JAM_BIT]) begin
      win_r <= 16'h0000;
    end else if (watching && !jam_start && sample_i.valid) begin
      if (declare) begin
        if (evt_cnt_r == 4'h0) begin
          win_r <= 16'h0000;
        end
      end else if (win_done) begin
        win_r <= 16'h0000;
      end else if (evt_cnt_r != 4'h0) begin
        win_r <= win_r + 16'h0001;
      end
    end
  end

  // Quiet interval while jammed; any event restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quiet_r <= 16'h0000;
    end else if (!ctrl_r[wld_pkg::JAM_BIT] || jam_start) begin
      quiet_r <= 16'h0000;
    end else if (!watching && sample_i.valid) begin
      if (declare || quiet_done) begin
        quiet_r <= 16'h0000;
      end else begin
        quiet_r <= quiet_r + 16'h0001;
      end
    end
  end

  // An event is reported only while watching and not the one that jams
  assign report = declare && watching && !jam_start;

  // Light event pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      light_event_o <= 1'b0;
    end else begin
      light_event_o <= report;
    end
  end

  // Motion inhibit pulse, one per reported event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motion_inhibit_o <= 1'b0;
    end else begin
      motion_inhibit_o <= report;
    end
  end

  // Trip level register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      light_trip_level_reg <= wld_pkg::TRIP_RST;
    end else if (wr_to(wb_adr_i, wld_pkg::ADDR_TRIP_LEVEL)) begin
      light_trip_level_reg <= wb_dat_i[7:0];
    end
  end

  // Debounce count and anti-jam enable, software owned; bits 2:1 stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r[7:1] <= wld_pkg::CTRL_RST[7:1];
    end else if (wr_to(wb_adr_i, wld_pkg::ADDR_CTRL_STATUS)) begin
      ctrl_r[7:3] <= wb_dat_i[7:3];
    end
  end

  // Event flag: hardware set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r[wld_pkg::EVT_BIT] <= wld_pkg::CTRL_RST[wld_pkg::EVT_BIT];
    end else if (light_event_o) begin
      ctrl_r[wld_pkg::EVT_BIT] <= 1'b1;
    end else if (wr_to(wb_adr_i, wld_pkg::ADDR_CTRL_STATUS) && !wb_dat_i[wld_pkg::EVT_BIT]) begin
      ctrl_r[wld_pkg::EVT_BIT] <= 1'b0;
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= '0;
    end else if (wr_to(wb_adr_i, wld_pkg::ADDR_IRQ_MASK)) begin
      irq_mask_r <= wb_dat_i[wld_pkg::IRQ_W-1:0];
    end
  end

  // Per-bit set and write-one-clear strobes
  assign irq_set = {jam_start, light_event_o};
  assign irq_clr = wr_to(wb_adr_i, wld_pkg::ADDR_IRQ_STATUS)
                 ? wb_dat_i[wld_pkg::IRQ_W-1:0] : '0;

  // Sticky status bits; a set in the same cycle as a clear wins
  generate
    for (genvar gi = 0; gi < wld_pkg::IRQ_W; gi++) begin : g_irq
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          irq_stat_r[gi] <= 1'b0;
        end else if (irq_set[gi]) begin
          irq_stat_r[gi] <= 1'b1;
        end else if (irq_clr[gi]) begin
          irq_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Level interrupt output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read multiplexer; unmapped offsets and reserved bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      wld_pkg::ADDR_TRIP_LEVEL: begin
        rd_word[7:0] = light_trip_level_reg;
      end
      wld_pkg::ADDR_CTRL_STATUS: begin
        rd_word[7:3] = light_control_status_reg[7:3];
        rd_word[0]   = light_control_status_reg[wld_pkg::EVT_BIT];
      end
      wld_pkg::ADDR_IRQ_STATUS: begin
        rd_word[wld_pkg::IRQ_W-1:0] = irq_stat_r;
      end
      wld_pkg::ADDR_IRQ_MASK: begin
        rd_word[wld_pkg::IRQ_W-1:0] = irq_mask_r;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Wishbone answer: ack one cycle after the request
  // Ack drops the cycle after it is given, so one pulse per request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req_live;
    end
  end

  // Read data registered alongside the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= rd_word;
    end
  end
endmodule

// *** wld_detector_props.sv ***
`timescale 1ns/1ps
module wld_detector_props (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire wld_pkg::wld_sample_t sample_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [3:0]           wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic                 motion_inhibit_o,
  input wire logic                 light_event_o
);
  logic       req_w;
  logic [7:0] trip_q;
  // Bus request waiting for its answer
  assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Shadow of the trip level
  always_ff @(posedge clk_i) begin
    if (rst_i) trip_q <= 8'h00;
    else if (req_w && wb_we_i && wb_sel_i[0] && wb_adr_i == wld_pkg::ADDR_TRIP_LEVEL)
      trip_q <= wb_dat_i[7:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ack_turn;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_follow: assert property (req_w |=> s_ack_turn) else $error("ack late");
  a_ack_cause: assert property (wb_ack_o |-> $past(req_w)) else $error("ack unasked");
  a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper bits set");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
    |-> wb_dat_o == 32'h0) else $error("unmapped read");
  a_pulse_pair: assert property (light_event_o == motion_inhibit_o)
    else $error("inhibit mismatch");
  a_over_trip: assert property (light_event_o |-> $past(sample_i.valid)
    && $past(sample_i.level) > $past(trip_q)) else $error("event without light");
  a_off_silent: assert property ($past(trip_q) == 8'h00 |-> !light_event_o)
    else $error("event while off");
  a_event_short: assert property (light_event_o && !$past(sample_i.valid) |-> 1'h0)
    else $error("event without sample");
endmodule
bind wld_detector wld_detector_props wld_chk_u (.*);

// *** wld_light_src.sv ***
`timescale 1ns/1ps
module wld_light_src (
  input  wire logic            clk_i,
  output wld_pkg::wld_sample_t sample_o
);
  initial sample_o = '0;
  // Sends n samples of one level, gap idle cycles after each
  task automatic burst(input logic [7:0] lv, input int n, input int gap);
    repeat (n) begin
      @(posedge clk_i);
      sample_o <= '{valid: 1'h1, level: lv};
      repeat (gap) begin
        @(posedge clk_i);
        sample_o <= '{valid: 1'h0, level: ~lv}; // Idle level never stale
      end
    end
    @(posedge clk_i);
    sample_o <= '{valid: 1'h0, level: ~lv};
  endtask
endmodule

// *** tb_white_light_detector.sv ***
`timescale 1ns/1ps
module tb_white_light_detector;
  logic                 clk_i, rst_i, cyc, stb, we, ack, ev, mi, irq;
  logic [3:0]           adr, sel, wsel;
  logic [31:0]          dat, rdat;
  wld_pkg::wld_sample_t smp;
  int                   failures, n_tests, ev_cnt, mi_cnt;
  wld_light_src src_u (.clk_i(clk_i), .sample_o(smp));
  wld_detector dut_u (.clk_i(clk_i), .rst_i(rst_i), .sample_i(smp), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .motion_inhibit_o(mi), .light_event_o(ev), .irq_o(irq));
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Light event pulse counter
  always @(posedge clk_i) if (ev === 1'h1) ev_cnt++;
  // Motion inhibit pulse counter
  always @(posedge clk_i) if (mi === 1'h1) mi_cnt++;
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Classic cycle; on a read d is the expected data
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; dat <= d;
    sel <= wsel;
    do @(posedge clk_i); while (ack !== 1'h1);
    if (!w) ck(rdat, d);
    cyc <= 1'h0; stb <= 1'h0;
  endtask
  task automatic chk_ev(input int e);
    repeat (4) @(posedge clk_i);
    #1 ck(32'(ev_cnt), 32'(e));
    ck(32'(mi_cnt), 32'(e));
    ev_cnt = 0;
    mi_cnt = 0;
  endtask
  task automatic complete_run;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000 failures++;
    complete_run;
  end
  // Main sequence
  initial begin
    rst_i = 1'h1; cyc = 1'h0; stb = 1'h0; we = 1'h0; adr = 4'h0; dat = 32'h0;
    sel = 4'h0; wsel = 4'hF;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(0, 4'h0, 32'h0); wb(0, 4'h4, 32'h0);
    wb(1, 4'h2, 32'h55); wb(0, 4'h2, 32'h0);
    src_u.burst(8'hFF, 3, 0); chk_ev(0);
    wb(1, 4'h0, 32'h10); wb(1, 4'h4, 32'h30); wb(0, 4'h0, 32'h10);
    wsel = 4'hE; wb(1, 4'h0, 32'h77); wsel = 4'hF; wb(0, 4'h0, 32'h10);
    src_u.burst(8'h11, 2, 3); src_u.burst(8'h10, 1, 0); src_u.burst(8'h11, 2, 0);
    chk_ev(0);
    src_u.burst(8'h11, 1, 0); chk_ev(1);
    wb(0, 4'h4, 32'h31);
    wb(1, 4'h4, 32'h31); wb(0, 4'h4, 32'h31);
    wb(1, 4'h4, 32'h30); wb(0, 4'h4, 32'h30);
    ck({31'h0, irq}, 32'h0); wb(1, 4'hC, 32'h1); repeat (3) @(posedge clk_i);
    ck({31'h0, irq}, 32'h1); wb(1, 4'h8, 32'h1); wb(0, 4'h8, 32'h0);
    ck({31'h0, irq}, 32'h0);
    wb(1, 4'h4, 32'h18); src_u.burst(8'h11, 14, 1); chk_ev(11);
    wb(0, 4'h8, 32'h3);
    src_u.burst(8'h00, wld_pkg::QUIET_PERIOD + 2, 0);
    src_u.burst(8'h11, 1, 0); chk_ev(1);
    wb(1, 4'h4, 32'h10); src_u.burst(8'h11, 14, 0); chk_ev(14);
    // Mid-run reset returns the trip level and control registers to zero
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(0, 4'h0, 32'h0); wb(0, 4'h4, 32'h0);
    complete_run;
  end
endmodule
